/* dhsp_regs.svh */
// Constants of the dual host serial port: widths, address base and strap bits, and timing counts.
`ifndef DHSP_REGS_SVH
`define DHSP_REGS_SVH

// ==========================================================================
// Byte and address layout
`define DHSP_BYTE_W 8
`define DHSP_ADDR_W 7
`define DHSP_ADDR_LOW_BIT 1
`define DHSP_ADDR_HIGH_BIT 2
`define DHSP_ADDR_BASE 7'h30
`define DHSP_BIT_LAST 3'h7
`define DHSP_LINK_CNT_FULL 4'h8

// ==========================================================================
// Clock rate and timing
`define DHSP_CLK_KHZ 100000
`define DHSP_WDC_HALF_MS 85
`define DHSP_WDC_HALF_CYC (`DHSP_WDC_HALF_MS * `DHSP_CLK_KHZ)
`define DHSP_AUDIO_IDLE_US 100
`define DHSP_AUDIO_IDLE_CYC ((`DHSP_AUDIO_IDLE_US * `DHSP_CLK_KHZ) / 1000)

`endif

/* dhsp_pkg.sv */
// Types shared by the dual host serial port design files.
package dhsp_pkg;

	// ======================================================================
	// Straps caught while the core is held in reset.
	typedef struct packed {
		logic mode_4w;
		logic autorun;
		logic unity_vol;
		logic addr_high;
		logic addr_low;
	} dhsp_strap_t;

	// ======================================================================
	// Byte handed to the core command interface.
	typedef struct packed {
		logic [7:0] data;
		logic via_i2c;
	} dhsp_rx_t;

	// ======================================================================
	// Two-wire slave states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_ADDR_ACK = 8'h04,
		ST_WR = 8'h08,
		ST_WR_ACK = 8'h10,
		ST_RD = 8'h20,
		ST_RD_ACK = 8'h40,
		ST_WAIT = 8'h80
	} dhsp_state_t;

endpackage

/* dhsp_sync.sv */
// Two-flop synchroniser bank for pins entering the system clock domain.
`timescale 1ns/10ps
module dhsp_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	// ======================================================================
	// The first stage is read only by the second stage.
	always_ff @(posedge i_clk) begin
		meta_r <= i_d;
		o_q <= meta_r;
	end
endmodule // dhsp_sync

/* dhsp_host_port.sv */
// Host control port: two-wire slave or four-wire serial, straps and alive pulse.
`timescale 1ns/10ps
`include "dhsp_regs.svh"

// Operation
// [R1] Select strap high picks four-wire, low two-wire.
// [R2] Every transfer carries one eight-bit byte.
// [R3] Two address bits come from two straps.
// [R4] Strap low gives 0, high gives 1.
// [R5] Two-wire transactions carry a single data byte.
// [R6] Two-wire slave works at 100k and 400k.
// [R7] Four-wire shifts in and out simultaneously.
// [R8] MSB first, active only while select low; here the input shift register moves on every clock rise.
// [R9] Input bit sampled on serial clock rise.
// [R10] Output changes on fall; MSB at select fall.
// [R11] Output released when deselected, open-drain when selected.
// [R12] Short frames right-align, delivered at select rise.
// [R13] Long frames keep the last eight bits.
// [R14] After LSB, output echoes received bits.
// [R15] Autorun strap starts processing, else await start.
// [R16] Mute strap sets initial unity or muted volume.
// [R17] Alive pulse toggles every 85 ms phase.
// [R18] Alive pulse stops when audio activity stops.
// [R19] Host watches alive pulse, resets if lost.
// [R20] Core held in reset while reset pin low.
// [R21] Pins synchronised; serial clock well below system clock.
// [R22] Byte strobed to core; response loaded beforehand.
module dhsp_host_port
	import dhsp_pkg::*;
#(
	parameter int WDC_HALF_CYC = `DHSP_WDC_HALF_CYC,
	parameter int AUDIO_IDLE_CYC = `DHSP_AUDIO_IDLE_CYC,
	parameter logic [6:0] ADDR_BASE = `DHSP_ADDR_BASE
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_host_sck,
	input wire logic i_serial_out_pin,
	output logic o_serial_out_pin,
	output logic o_serial_out_pin_oe,
	input wire logic i_slave_addr_strap_low,
	input wire logic i_host_select_n,
	input wire logic i_mode_sel_strap,
	input wire logic i_autorun_strap,
	input wire logic i_initial_mute_strap_n,
	input wire logic i_core_reset_n,
	input wire logic i_audio_lrclk,
	input wire logic i_start_cmd,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_byte,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output dhsp_rx_t o_rx,
	output logic o_core_rst,
	output logic o_run,
	output logic o_vol_unity,
	output logic o_alive_pulse_out,
	output logic o_alive_pulse_out_oe
);
	localparam int WDC_W = $clog2(WDC_HALF_CYC + 1);
	localparam int IDLE_W = $clog2(AUDIO_IDLE_CYC + 1);

	// Picks a bit of a byte counted from the MSB.
	function automatic logic msb_bit(input logic [7:0] b, input logic [3:0] n);
		logic [2:0] idx;
		idx = 3'(4'h7 - n);
		return b[idx];
	endfunction

	// ======================================================================
	// Pin synchronisers
	logic [8:0] pin_raw;
	logic [8:0] pin_s;
	logic scl_s, sda_s, adl_s, ssn_s, sel_s, auto_s, mute_n_s, rstn_s, lr_s;
	assign pin_raw = {i_audio_lrclk, i_core_reset_n, i_initial_mute_strap_n, i_autorun_strap,
		i_mode_sel_strap, i_host_select_n, i_slave_addr_strap_low, i_serial_out_pin, i_host_sck};
	assign {lr_s, rstn_s, mute_n_s, auto_s, sel_s, ssn_s, adl_s, sda_s, scl_s} = pin_s;

	dhsp_sync #(.W(9)) u_sync ( // [R21]
		.i_clk(i_clk),
		.i_d(pin_raw),
		.o_q(pin_s)
	);

	// ======================================================================
	// Core reset and straps
	logic core_rst_r;
	dhsp_strap_t strap_r;
	logic run_r;
	logic [6:0] addr;

	// The core stays in reset while either reset is asserted.
	always_ff @(posedge i_clk) begin
		core_rst_r <= i_rst | ~rstn_s; // [R20]
	end

	// Straps are sampled all through reset and frozen at its release.
	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			strap_r.mode_4w <= sel_s; // [R1]
			strap_r.autorun <= auto_s;
			strap_r.unity_vol <= mute_n_s; // [R16]
			strap_r.addr_high <= ssn_s; // [R4]
			strap_r.addr_low <= adl_s; // [R4]
		end
	end

	// The address pins replace two bits of the fixed base address.
	assign addr = {ADDR_BASE[6:3], strap_r.addr_high, strap_r.addr_low, ADDR_BASE[0]}; // [R3]

	// Run state follows the autorun strap, or a start command later.
	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			run_r <= auto_s; // [R15]
		end else if (i_start_cmd) begin
			run_r <= 1'b1; // [R15]
		end
	end

	assign o_core_rst = core_rst_r;
	assign o_run = run_r;
	assign o_vol_unity = strap_r.unity_vol;

	// ======================================================================
	// Four-wire link, clocked by the host serial clock
	// Select high is the frame's own end and clears the count and output flops at once,
	// so nothing here waits for an edge that a stopped clock never gives.
	logic [7:0] tx_r;
	logic [7:0] lk_shift_r;
	logic [3:0] lk_cnt_r;
	logic lk_out_r;
	logic lk_fell_r;
	logic lk_level;

	// Rising edges move the input bit in, MSB first.
	always_ff @(posedge i_host_sck) begin
		lk_shift_r <= {lk_shift_r[6:0], i_slave_addr_strap_low}; // [R9] [R13]
	end

	// Count of rising edges in this frame, saturating at eight.
	always_ff @(posedge i_host_sck or posedge i_host_select_n) begin
		if (i_host_select_n) begin
			lk_cnt_r <= 4'h0;
		end else if (lk_cnt_r != `DHSP_LINK_CNT_FULL) begin
			lk_cnt_r <= lk_cnt_r + 4'h1; // [R8]
		end
	end

	// Falling edges present the next response bit, then echo the input.
	always_ff @(negedge i_host_sck or posedge i_host_select_n) begin
		if (i_host_select_n) begin
			lk_fell_r <= 1'b0;
			lk_out_r <= 1'b1;
		end else begin
			lk_fell_r <= 1'b1;
			if (lk_cnt_r == `DHSP_LINK_CNT_FULL) begin
				lk_out_r <= lk_shift_r[7]; // [R14]
			end else begin
				lk_out_r <= msb_bit(tx_r, lk_cnt_r); // [R10] [R7]
			end
		end
	end

	// Before the first falling edge the MSB shows from the select fall.
	assign lk_level = lk_fell_r ? lk_out_r : tx_r[7]; // [R10]

	// ======================================================================
	// Two-wire slave, oversampled on the system clock
	dhsp_state_t st_r;
	logic scl_d_r, sda_d_r;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic [2:0] bit_cnt_r;
	logic [7:0] i2c_sh_r;
	logic rw_r;
	logic pull_r;
	logic i2c_rx_pulse;

	// Previous samples for edge and condition detection.
	always_ff @(posedge i_clk) begin
		scl_d_r <= scl_s;
		sda_d_r <= sda_s;
	end

	// Both lines share one synchroniser latency, so their order is kept;
	// even 400 kbit/s leaves hundreds of system clocks per bit.
	assign scl_rise = scl_s & ~scl_d_r; // [R6]
	assign scl_fall = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign i2c_rx_pulse = (st_r == ST_WR) & scl_rise & (bit_cnt_r == `DHSP_BIT_LAST);

	// Protocol state machine; pull_r drives the data line low.
	always_ff @(posedge i_clk) begin
		if (core_rst_r || strap_r.mode_4w) begin
			st_r <= ST_IDLE;
			bit_cnt_r <= 3'h0;
			pull_r <= 1'b0;
			rw_r <= 1'b0;
			i2c_sh_r <= 8'h00;
		end else if (bus_start) begin
			st_r <= ST_ADDR;
			bit_cnt_r <= 3'h0;
			pull_r <= 1'b0;
		end else if (bus_stop) begin
			st_r <= ST_IDLE;
			pull_r <= 1'b0;
		end else begin
			case (st_r)
				ST_ADDR: begin
					if (scl_rise) begin
						i2c_sh_r <= {i2c_sh_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == `DHSP_BIT_LAST) begin
							rw_r <= sda_s;
							st_r <= (i2c_sh_r[6:0] == addr) ? ST_ADDR_ACK : ST_WAIT; // [R3]
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (!pull_r) begin
							pull_r <= 1'b1;
						end else if (rw_r) begin
							st_r <= ST_RD;
							pull_r <= ~tx_r[7];
						end else begin
							st_r <= ST_WR;
							pull_r <= 1'b0;
						end
					end
				end
				ST_WR: begin
					if (scl_rise) begin
						i2c_sh_r <= {i2c_sh_r[6:0], sda_s}; // [R2]
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == `DHSP_BIT_LAST) begin
							st_r <= ST_WR_ACK;
						end
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						if (!pull_r) begin
							pull_r <= 1'b1;
						end else begin
							pull_r <= 1'b0;
							st_r <= ST_WAIT; // [R5]
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == `DHSP_BIT_LAST) begin
							pull_r <= 1'b0;
							st_r <= ST_RD_ACK;
						end else begin
							pull_r <= ~msb_bit(tx_r, {1'b0, bit_cnt_r + 3'h1});
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						st_r <= ST_WAIT; // [R5]
					end
				end
				ST_WAIT: begin
					pull_r <= 1'b0;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Core command interface
	logic ssn_d_r;
	logic frame_end;

	always_ff @(posedge i_clk) begin
		ssn_d_r <= ssn_s;
	end

	// The link byte is stable here: the host clock idles while deselected
	// and select passed two flops after the last rising edge.
	assign frame_end = strap_r.mode_4w & ~core_rst_r & ssn_s & ~ssn_d_r;

	// One-cycle strobe for each finished byte from either protocol.
	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			o_rx_valid <= 1'b0;
			o_rx <= '0;
		end else begin
			o_rx_valid <= frame_end | i2c_rx_pulse; // [R22]
			if (frame_end) begin
				o_rx <= '{data: lk_shift_r, via_i2c: 1'b0}; // [R12] [R13]
			end else if (i2c_rx_pulse) begin
				o_rx <= '{data: {i2c_sh_r[6:0], sda_s}, via_i2c: 1'b1};
			end
		end
	end

	// Response byte may only change while no transfer is running.
	assign o_tx_ready = strap_r.mode_4w ? (ssn_s & i_host_select_n) : (st_r == ST_IDLE); // [R22]

	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			tx_r <= 8'h00;
		end else if (i_tx_valid && o_tx_ready) begin
			tx_r <= i_tx_byte; // [R22]
		end
	end

	// ======================================================================
	// Shared data pin, open drain in both modes
	assign o_serial_out_pin = 1'b0;
	assign o_serial_out_pin_oe = strap_r.mode_4w ? (~i_host_select_n & ~lk_level) : pull_r; // [R11]

	// ======================================================================
	// Alive pulse, advancing only while the audio frame clock moves
	logic lr_d_r;
	logic [IDLE_W-1:0] idle_cnt_r;
	logic audio_active;
	logic [WDC_W-1:0] wdc_cnt_r;
	logic wdc_phase_r;
	logic wdc_run;

	always_ff @(posedge i_clk) begin
		lr_d_r <= lr_s;
	end

	// Any frame clock edge restarts the idle timer.
	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			idle_cnt_r <= IDLE_W'(AUDIO_IDLE_CYC);
		end else if (lr_s != lr_d_r) begin
			idle_cnt_r <= '0;
		end else if (idle_cnt_r != IDLE_W'(AUDIO_IDLE_CYC)) begin
			idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
		end
	end

	assign audio_active = idle_cnt_r != IDLE_W'(AUDIO_IDLE_CYC); // [R18]
	assign wdc_run = run_r & audio_active;

	// Each low and high phase lasts the full half period.
	always_ff @(posedge i_clk) begin
		if (core_rst_r) begin
			wdc_cnt_r <= '0;
			wdc_phase_r <= 1'b1;
		end else if (wdc_run) begin
			if (wdc_cnt_r == WDC_W'(WDC_HALF_CYC - 1)) begin
				wdc_cnt_r <= '0;
				wdc_phase_r <= ~wdc_phase_r; // [R17]
			end else begin
				wdc_cnt_r <= wdc_cnt_r + WDC_W'(1);
			end
		end
	end

	assign o_alive_pulse_out = 1'b0;
	assign o_alive_pulse_out_oe = ~wdc_phase_r;

	// ======================================================================
	// Checks
	a_core_rst_hold: assert property (@(posedge i_clk) !rstn_s |=> core_rst_r) // [R20]
		else $error("core not held in reset");
	a_mode_strap: assert property (@(posedge i_clk) $fell(core_rst_r) |-> strap_r.mode_4w == $past(sel_s)) // [R1]
		else $error("mode strap not caught at release");
	a_addr_strap: assert property (@(posedge i_clk) $fell(core_rst_r) |-> // [R4]
		addr[2] == $past(ssn_s) && addr[1] == $past(adl_s))
		else $error("address strap bits wrong");
	a_frame_byte: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
		frame_end |=> o_rx_valid && o_rx.data == $past(lk_shift_r) && !o_rx.via_i2c)
		else $error("four-wire byte not delivered");
	a_rx_single: assert property (@(posedge i_clk) disable iff (i_rst) o_rx_valid |=> !o_rx_valid) // [R22]
		else $error("receive strobe longer than one cycle");
	a_i2c_one_byte: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
		st_r == ST_WR_ACK && scl_fall && pull_r && !bus_start && !bus_stop |=> st_r == ST_WAIT && !pull_r)
		else $error("second byte accepted");
	// Keyed to the pin itself: the synchronised select lags the pin, and a low MSB
	// already pulls the line in the two cycles after the pin falls.
	a_out_release: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
		strap_r.mode_4w && i_host_select_n |-> !o_serial_out_pin_oe && !lk_fell_r && lk_cnt_r == 4'h0)
		else $error("output driven while deselected");
	a_wdc_halt: assert property (@(posedge i_clk) disable iff (core_rst_r) // [R18]
		!audio_active |=> $stable(wdc_phase_r) && $stable(wdc_cnt_r))
		else $error("alive pulse moved without audio");
	a_wdc_toggle: assert property (@(posedge i_clk) disable iff (core_rst_r) // [R17]
		wdc_run && wdc_cnt_r == WDC_W'(WDC_HALF_CYC - 1) |=> wdc_phase_r != $past(wdc_phase_r) && wdc_cnt_r == '0)
		else $error("alive pulse phase not toggled");
	a_run_hold: assert property (@(posedge i_clk) disable iff (core_rst_r) // [R15]
		run_r |=> run_r)
		else $error("run dropped without reset");
endmodule // dhsp_host_port

/* dhsp_host_model.sv */
// Host controller model that drives the four-wire and two-wire host port pins.
`timescale 1ns/10ps
module dhsp_host_model (
	input wire logic i_sda,
	output logic o_sck,
	output logic o_serial_in_pin,
	output logic o_ssn,
	output logic o_sda_low
);
	// ==========================================================
	// Pin state; the serial clock stands still between frames.
	int half = 1250;
	// The link count and output flops clear on a rising select or a clock edge while select is high; the clock stands still, so power-up gives a rising select.
	initial begin
		o_sck = 1'b0;
		o_serial_in_pin = 1'b0;
		o_ssn = 1'b0;
		o_sda_low = 1'b0;
		#1 o_ssn = 1'b1;
	end

	// In two-wire mode the data-in and select pins act as address straps.
	task automatic strap(input logic a1, input logic a2);
		o_serial_in_pin = a1;
		o_ssn = a2;
	endtask

	// ==========================================================
	// One four-wire frame of n bits; dout collects the returned bits.
	task automatic xfer(input int n, input logic [15:0] din, output logic [15:0] dout);
		dout = 16'h0;
		#7 o_ssn = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_serial_in_pin = din[i];
			#80 o_sck = 1'b1;
			dout[i] = i_sda;
			#80 o_sck = 1'b0;
		end
		#80 o_ssn = 1'b1;
		// A released line must not keep showing the last bit.
		o_serial_in_pin = ~o_serial_in_pin;
	endtask

	// ==========================================================
	// Two-wire conditions; data moves a quarter phase after the clock falls.
	task automatic i2c_start();
		o_sck = 1'b1;
		o_sda_low = 1'b0;
		#(half) o_sda_low = 1'b1;
		#(half) o_sck = 1'b0;
	endtask

	// One byte plus the acknowledge slot; ack is high when the device pulled low.
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#(half / 4) o_sda_low = ~b[i];
			#(half) o_sck = 1'b1;
			#(half) o_sck = 1'b0;
		end
		#(half / 4) o_sda_low = 1'b0;
		#(half) o_sck = 1'b1;
		ack = ~i_sda;
		#(half) o_sck = 1'b0;
	endtask

	// One byte read from the device; the master leaves the acknowledge high.
	task automatic i2c_read(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			#(half / 4) o_sda_low = 1'b0;
			#(half) o_sck = 1'b1;
			d[i] = i_sda;
			#(half) o_sck = 1'b0;
		end
		#(half / 4) o_sda_low = 1'b0;
		#(half) o_sck = 1'b1;
		#(half) o_sck = 1'b0;
	endtask

	task automatic i2c_stop();
		#(half / 4) o_sda_low = 1'b1;
		#(half) o_sck = 1'b1;
		#(half) o_sda_low = 1'b0;
		#(half);
	endtask
endmodule // dhsp_host_model

/* dhsp_host_port_tb_top.sv */
// Self-checking bench for the dual host serial port.
`timescale 1ns/10ps
module dhsp_host_port_tb_top;
	import dhsp_pkg::*;
	// ==========================================================
	// Stimulus and observed signals.
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic mode = 1'b1;
	logic autorun = 1'b0;
	logic mute_n = 1'b0;
	logic core_rst_n = 1'b1;
	logic lrclk = 1'b0;
	logic start = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic lr_en = 1'b0;
	logic al_prev = 1'b0;
	logic sck, serial_in_pin, ssn, sda_low, sda, oe, sdo, tx_ready, rx_valid;
	logic core_rst, run, vol, al_out, al_oe, ack;
	logic [15:0] got;
	dhsp_rx_t rx, rx_q;
	int n_fail = 0;
	int cmp_count = 0;
	int rx_n = 0;
	int tog = 0;
	int cyc = 0;
	int n_i2c = 0;
	logic [7:0] rd;

	always #5 i_clk = ~i_clk;

	// The data pin has a pull-up, so it is low only while someone pulls it.
	assign sda = ~(oe | sda_low);

	dhsp_host_port #(.WDC_HALF_CYC(20), .AUDIO_IDLE_CYC(16)) u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_host_sck(sck), .i_serial_out_pin(sda),
		.o_serial_out_pin(sdo), .o_serial_out_pin_oe(oe), .i_slave_addr_strap_low(serial_in_pin),
		.i_host_select_n(ssn), .i_mode_sel_strap(mode), .i_autorun_strap(autorun),
		.i_initial_mute_strap_n(mute_n), .i_core_reset_n(core_rst_n), .i_audio_lrclk(lrclk),
		.i_start_cmd(start), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_tx_ready(tx_ready),
		.o_rx_valid(rx_valid), .o_rx(rx), .o_core_rst(core_rst), .o_run(run), .o_vol_unity(vol),
		.o_alive_pulse_out(al_out), .o_alive_pulse_out_oe(al_oe));

	dhsp_host_model u_host (.i_sda(sda), .o_sck(sck), .o_serial_in_pin(serial_in_pin), .o_ssn(ssn), .o_sda_low(sda_low));

	// Capture strobed bytes, count alive toggles, run the frame clock, cut a hang.
	always @(posedge i_clk) begin
		cyc++;
		if (rx_valid === 1'b1) begin
			rx_q <= rx;
			rx_n++;
		end
		if (al_oe !== al_prev) tog++;
		al_prev <= al_oe;
		if (lr_en && cyc % 4 == 0) lrclk <= ~lrclk;
		if (cyc == 60000) begin
			n_fail++;
			end_sim();
		end
	end

	// ==========================================================
	// Shared tasks.
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
		cmp_count++;
		if (act !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, act);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic load_tx(input logic [7:0] b);
		@(posedge i_clk);
		chk("tx_ready", 16'h1, {15'h0, tx_ready});
		tx_valid <= 1'b1;
		tx_byte <= b;
		@(posedge i_clk);
		tx_valid <= 1'b0;
	endtask

	task automatic rx_chk(input logic [7:0] d, input logic via, input int n0);
		wait_clk(10);
		chk("rx_data", {8'h0, d}, {8'h0, rx_q.data});
		chk("rx_via", {15'h0, via}, {15'h0, rx_q.via_i2c});
		chk("rx_count", 16'(n0 + 1), 16'(rx_n));
	endtask

	// Frame of n bits; the output is released both before and after it.
	task automatic spi(input int n, input logic [15:0] din, input logic [7:0] tx, input logic [15:0] xo,
		input logic [7:0] xr);
		int n0;
		load_tx(tx);
		n0 = rx_n;
		chk("oe_idle", 16'h0, {15'h0, oe});
		u_host.xfer(n, din, got);
		rx_chk(xr, 1'b0, n0);
		chk("dout", xo, got);
		chk("oe_after", 16'h0, {15'h0, oe});
	endtask

	task automatic ib(input logic [7:0] b, input logic e);
		u_host.i2c_byte(b, ack);
		chk("ack", {15'h0, e}, {15'h0, ack});
	endtask

	task automatic end_sim();
		$display("TB: checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence: straps, alive pulse, four-wire frames, then two-wire.
	initial begin
		wait_clk(6);
		chk("core_rst", 16'h1, {15'h0, core_rst});
		i_rst <= 1'b0;
		wait_clk(6);
		chk("run_wait", 16'h0, {15'h0, run});
		chk("vol_mute", 16'h0, {15'h0, vol});
		chk("sdo", 16'h0, {15'h0, sdo});
		chk("al_out", 16'h0, {15'h0, al_out});
		lr_en <= 1'b1;
		wait_clk(20);
		tog = 0;
		wait_clk(100);
		chk("tog_stopped", 16'h0, 16'(tog));
		start <= 1'b1;
		wait_clk(1);
		start <= 1'b0;
		wait_clk(4);
		chk("run_start", 16'h1, {15'h0, run});
		tog = 0;
		wait_clk(100);
		chk("tog_run", 16'h1, {15'h0, (tog >= 4 && tog <= 6)});
		lr_en <= 1'b0;
		wait_clk(40);
		tog = 0;
		wait_clk(100);
		chk("tog_idle", 16'h0, 16'(tog));
		spi(8, 16'h003c, 8'ha5, 16'h00a5, 8'h3c);
		spi(5, 16'h0015, 8'h5a, 16'h000b, 8'h95);
		spi(12, 16'h0abc, 8'hc3, 16'h0c3a, 8'hbc);
		core_rst_n <= 1'b0;
		mode <= 1'b0;
		autorun <= 1'b1;
		mute_n <= 1'b1;
		u_host.strap(1'b1, 1'b0);
		wait_clk(5);
		chk("core_rst_pin", 16'h1, {15'h0, core_rst});
		core_rst_n <= 1'b1;
		wait_clk(6);
		chk("run_auto", 16'h1, {15'h0, run});
		chk("vol_unity", 16'h1, {15'h0, vol});
		// Byte counts are taken before the first two transactions, since the strobe comes mid-way; the last check reuses the second count.
		n_i2c = rx_n;
		u_host.i2c_start();
		ib(8'h64, 1'b1);
		ib(8'h5a, 1'b1);
		ib(8'h77, 1'b0);
		u_host.i2c_stop();
		rx_chk(8'h5a, 1'b1, n_i2c);
		n_i2c = rx_n;
		u_host.i2c_start();
		ib(8'h60, 1'b0);
		u_host.i2c_stop();
		// A read returns the loaded response byte once, then the line stays released.
		load_tx(8'h96);
		u_host.i2c_start();
		ib(8'h65, 1'b1);
		chk("tx_busy", 16'h0, {15'h0, tx_ready});
		u_host.i2c_read(rd);
		chk("rd_byte", 16'h0096, {8'h0, rd});
		u_host.i2c_read(rd);
		chk("rd_second", 16'h00ff, {8'h0, rd});
		u_host.i2c_stop();
		u_host.half = 5000;
		u_host.i2c_start();
		ib(8'h64, 1'b1);
		ib(8'h81, 1'b1);
		u_host.i2c_stop();
		rx_chk(8'h81, 1'b1, n_i2c);
		end_sim();
	end
endmodule // dhsp_host_port_tb_top
